// [design/boot_mode_decode.sv]
// Combinational boot mode decode from the two strap levels
`default_nettype none
module boot_mode_decode (
  // Strap levels and software option
  input  wire logic                      downloadSelectStrap,
  input  wire logic                      bootSourceStrap,
  input  wire logic                      spiDownloadReq,
  // Decoded mode
  output var boot_strap_pkg::boot_mode_t mode
);
  always_comb begin
    if (bootSourceStrap) begin
      mode = boot_strap_pkg::MODE_FLASH;
    end else if (downloadSelectStrap) begin
      mode = spiDownloadReq ? boot_strap_pkg::MODE_SPI_DL : boot_strap_pkg::MODE_DOWNLOAD;
    end else begin
      mode = boot_strap_pkg::MODE_INVALID;
    end
  end
endmodule
`default_nettype wire

// [design/boot_strap_mode_select.sv]
// Boot strap capture, mode select, pin hand-back and AXI4-Lite registers
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`default_nettype none
module boot_strap_mode_select #(
  parameter int          HOLD_CYC    = boot_strap_pkg::STRAP_HOLD_CYC,
  parameter int          NUM_UART    = 2,
  parameter int          ROUTE_W     = 5,
  parameter logic [7:0]  SILICON_REV = boot_strap_pkg::REV_V11,
  // Arbitrary identification value
  parameter logic [15:0] BLOCK_ID    = 16'h5a5a
) (
  // Clock and reset (rst is the chip enable inverted)
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Strap pins
  input  wire logic                        downloadSelectStrapPin,
  input  wire logic                        bootSourceStrapPin,
  // Strap pins in ordinary use after capture
  output logic                             strapPinsReleased,
  output logic      [1:0]                  strapPinsGpio,
  // Boot outcome
  output var boot_strap_pkg::boot_mode_t   bootMode,
  output logic                             bootModeValid,
  output logic                             invalidStraps,
  output logic                             serialDownloadEn,
  output logic                             spiDownloadEn,
  output logic                             primarySerialPortLogEn,
  // Clock source selection
  output logic                             rtcExtClockEn,
  output logic                             rtcSquareInput,
  output logic                             rtcPinsAsGpio,
  output logic                             xtal40mSel,
  // Extra serial port routing
  output logic      [NUM_UART*ROUTE_W-1:0] uartPinRoute,
  // AXI4-Lite slave
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  localparam int CW = $clog2(HOLD_CYC + 1);

  logic [1:0]                  strapSync;
  boot_strap_pkg::boot_mode_t  decodedMode;
  boot_strap_pkg::cap_state_t  capState;
  boot_strap_pkg::cap_state_t  next_capState;
  logic [CW-1:0]               holdCnt;
  logic [CW-1:0]               next_holdCnt;
  boot_strap_pkg::boot_mode_t  next_bootMode;
  logic                        next_bootModeValid;
  logic [1:0]                  capStraps;
  logic [1:0]                  next_capStraps;
  logic [31:0]                 control;
  logic [31:0]                 next_control;
  logic [31:0]                 uartRoute;
  logic [31:0]                 next_uartRoute;
  logic                        awHeld;
  logic                        next_awHeld;
  logic [7:0]                  awAddr;
  logic [7:0]                  next_awAddr;
  logic                        wHeld;
  logic                        next_wHeld;
  logic [31:0]                 wData;
  logic [31:0]                 next_wData;
  logic [3:0]                  wStrb;
  logic [3:0]                  next_wStrb;
  logic                        next_bvalid;
  logic [1:0]                  next_bresp;
  logic                        next_rvalid;
  logic [31:0]                 next_rdata;
  logic [1:0]                  next_rresp;

  // Merge byte lanes into a register word
  function automatic logic [31:0] applyStrb(input logic [31:0] oldVal,
                                            input logic [31:0] newVal,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Strap pins come from the board, so they are synchronised first
  strap_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .pinIn   ({bootSourceStrapPin, downloadSelectStrapPin}),
    .syncOut (strapSync)
  );

  boot_mode_decode u_decode (
    .downloadSelectStrap (capStraps[0]),
    .bootSourceStrap     (capStraps[1]),
    .spiDownloadReq      (control[boot_strap_pkg::CTL_SPI_DL]),
    .mode                (decodedMode)
  );

  // Capture sequencer: wait out the hold window after release, then latch
  always_comb begin
    next_capState      = capState;
    next_holdCnt       = holdCnt;
    next_capStraps     = capStraps;
    next_bootMode      = bootMode;
    next_bootModeValid = bootModeValid;
    case (capState)
      boot_strap_pkg::CAP_IDLE: begin
        next_holdCnt  = '0;
        next_capState = boot_strap_pkg::CAP_HOLD;
      end
      boot_strap_pkg::CAP_HOLD: begin
        next_capStraps = strapSync;
        if (holdCnt >= CW'(HOLD_CYC - 1)) begin
          next_capState = boot_strap_pkg::CAP_DONE;
        end else begin
          next_holdCnt = holdCnt + CW'(1);
        end
      end
      boot_strap_pkg::CAP_DONE: begin
        if (!bootModeValid) begin
          next_bootMode      = decodedMode;
          next_bootModeValid = 1'b1;
        end
      end
      default: begin
        next_capState = boot_strap_pkg::CAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capState      <= boot_strap_pkg::CAP_IDLE;
      holdCnt       <= '0;
      capStraps     <= 2'b10;
      bootMode      <= boot_strap_pkg::MODE_FLASH;
      bootModeValid <= 1'b0;
    end else begin
      capState      <= next_capState;
      holdCnt       <= next_holdCnt;
      capStraps     <= next_capStraps;
      bootMode      <= next_bootMode;
      bootModeValid <= next_bootModeValid;
    end
  end

  always_comb begin
    strapPinsReleased      = bootModeValid;
    strapPinsGpio          = bootModeValid ? strapSync : 2'b00;
    invalidStraps          = bootModeValid && (bootMode == boot_strap_pkg::MODE_INVALID);
    serialDownloadEn       = bootModeValid && (bootMode == boot_strap_pkg::MODE_DOWNLOAD);
    spiDownloadEn          = bootModeValid && (bootMode == boot_strap_pkg::MODE_SPI_DL);
    primarySerialPortLogEn = bootModeValid && !invalidStraps;
    rtcExtClockEn          = control[boot_strap_pkg::CTL_RTC_EXT];
    rtcSquareInput         = control[boot_strap_pkg::CTL_RTC_EXT] &&
                             control[boot_strap_pkg::CTL_RTC_SQUARE];
    rtcPinsAsGpio          = !control[boot_strap_pkg::CTL_RTC_EXT];
    // 40 MHz only on new silicon
    xtal40mSel             = control[boot_strap_pkg::CTL_XTAL_40M] &&
                             (SILICON_REV >= boot_strap_pkg::REV_V11);
    uartPinRoute           = uartRoute[NUM_UART*ROUTE_W-1:0];
  end

  // AXI4-Lite write path: address and data taken in either order
  always_comb begin
    next_awHeld    = awHeld;
    next_awAddr    = awAddr;
    next_wHeld     = wHeld;
    next_wData     = wData;
    next_wStrb     = wStrb;
    next_bvalid    = s_axi_bvalid;
    next_bresp     = s_axi_bresp;
    next_control   = control;
    next_uartRoute = uartRoute;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (awHeld && wHeld && !s_axi_bvalid) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = boot_strap_pkg::RESP_OKAY;
      case ({awAddr[7:2], 2'b00})
        boot_strap_pkg::ADDR_CONTROL: begin
          next_control = applyStrb(control, wData, wStrb) & 32'h0000_000f;
        end
        boot_strap_pkg::ADDR_UART_ROUTE: begin
          next_uartRoute = applyStrb(uartRoute, wData, wStrb);
        end
        boot_strap_pkg::ADDR_STATUS,
        boot_strap_pkg::ADDR_ID: begin
        end
        default: begin
          next_bresp = boot_strap_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    s_axi_awready = !awHeld;
    s_axi_wready  = !wHeld;
    s_axi_arready = !s_axi_rvalid;
  end

  // AXI4-Lite read path
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = boot_strap_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        boot_strap_pkg::ADDR_STATUS: begin
          next_rdata = {24'h00_0000, capStraps, invalidStraps, bootModeValid,
                        2'b00, bootMode};
        end
        boot_strap_pkg::ADDR_CONTROL: begin
          next_rdata = control;
        end
        boot_strap_pkg::ADDR_UART_ROUTE: begin
          next_rdata = uartRoute;
        end
        boot_strap_pkg::ADDR_ID: begin
          next_rdata = {SILICON_REV, 8'h00, BLOCK_ID};
        end
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = boot_strap_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld       <= 1'b0;
      awAddr       <= 8'h00;
      wHeld        <= 1'b0;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= boot_strap_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= boot_strap_pkg::RESP_OKAY;
      control      <= boot_strap_pkg::CONTROL_RESET;
      uartRoute    <= boot_strap_pkg::UART_ROUTE_RESET;
    end else begin
      awHeld       <= next_awHeld;
      awAddr       <= next_awAddr;
      wHeld        <= next_wHeld;
      wData        <= next_wData;
      wStrb        <= next_wStrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      control      <= next_control;
      uartRoute    <= next_uartRoute;
    end
  end
endmodule
`default_nettype wire

// [design/boot_strap_pkg.sv]
// Shared constants and types for the boot strap mode select block
`default_nettype none
package boot_strap_pkg;
  // Boot mode codes
  typedef enum logic [1:0] {
    MODE_FLASH    = 2'b00,
    MODE_DOWNLOAD = 2'b01,
    MODE_SPI_DL   = 2'b10,
    MODE_INVALID  = 2'b11
  } boot_mode_t;

  // Capture sequencer states
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_HOLD = 2'b01,
    CAP_DONE = 2'b10
  } cap_state_t;

  // Main clock rate, strap hold window and enable low time
  localparam int          CLK_HZ           = 10000000;
  localparam int          STRAP_HOLD_MS    = 3;
  localparam int          STRAP_HOLD_CYC   = (STRAP_HOLD_MS * (CLK_HZ / 1000));
  localparam int          EN_LOW_US        = 50;
  localparam int          EN_LOW_CYC       = (EN_LOW_US * (CLK_HZ / 1000000));

  // Reference crystal options and silicon revision
  localparam logic [1:0]  XTAL_26M         = 2'h0;
  localparam logic [1:0]  XTAL_40M         = 2'h1;
  localparam logic [7:0]  REV_V11          = 8'h11;

  // AXI register byte addresses
  localparam logic [7:0]  ADDR_STATUS      = 8'h00;
  localparam logic [7:0]  ADDR_CONTROL     = 8'h04;
  localparam logic [7:0]  ADDR_UART_ROUTE  = 8'h08;
  localparam logic [7:0]  ADDR_ID          = 8'h0c;

  // Reset values
  localparam logic [31:0] CONTROL_RESET    = 32'h0000_0000;
  localparam logic [31:0] UART_ROUTE_RESET = 32'h0000_0000;

  // Control field positions
  localparam int          CTL_SPI_DL       = 0;
  localparam int          CTL_RTC_EXT      = 1;
  localparam int          CTL_RTC_SQUARE   = 2;
  localparam int          CTL_XTAL_40M     = 3;

  // Response codes
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage
`default_nettype wire

// [design/strap_sync.sv]
// Two-flop synchroniser for a bus of pin levels
`default_nettype none
module strap_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Pins in, synchronised out
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_syncOut;

  always_comb begin
    next_stage1  = pinIn;
    next_syncOut = stage1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end
endmodule
`default_nettype wire

// [verif/boot_strap_checker.sv]
// Concurrent checks on the boot strap mode select ports
`default_nettype none
module boot_strap_checker #(
  parameter int HOLD_CYC = 8
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // Strap pins
  input wire logic                       downloadSelectStrapPin,
  input wire logic                       bootSourceStrapPin,
  // Boot outcome
  input wire logic                       strapPinsReleased,
  input wire logic [1:0]                 strapPinsGpio,
  input wire boot_strap_pkg::boot_mode_t bootMode,
  input wire logic                       bootModeValid,
  input wire logic                       invalidStraps,
  input wire logic                       serialDownloadEn,
  input wire logic                       spiDownloadEn,
  input wire logic                       primarySerialPortLogEn,
  input wire logic                       rtcExtClockEn,
  input wire logic                       rtcPinsAsGpio
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] relCnt;
  logic [7:0] next_relCnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Cycles since reset release, saturating
  always_comb begin
    next_relCnt = (relCnt == 8'hff) ? relCnt : relCnt + 8'h01;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      relCnt <= 8'h00;
    end else begin
      relCnt <= next_relCnt;
    end
  end

  property p_valid_time;
    bootModeValid == (relCnt >= HOLD_CYC + 2);
  endproperty
  a_valid_time: assert property (p_valid_time)
    else $error("mode valid at wrong cycle");
  property p_mode_hold;
    bootModeValid && $past(bootModeValid) |-> $stable(bootMode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("captured mode changed");
  property p_invalid;
    invalidStraps == (bootModeValid && bootMode == boot_strap_pkg::MODE_INVALID);
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("invalid flag wrong");
  property p_serial;
    serialDownloadEn == (bootModeValid && bootMode == boot_strap_pkg::MODE_DOWNLOAD);
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial download enable wrong");
  property p_spi;
    spiDownloadEn == (bootModeValid && bootMode == boot_strap_pkg::MODE_SPI_DL);
  endproperty
  a_spi: assert property (p_spi)
    else $error("spi download enable wrong");
  property p_log;
    primarySerialPortLogEn == (bootModeValid && !invalidStraps);
  endproperty
  a_log: assert property (p_log)
    else $error("log enable wrong");
  property p_release;
    strapPinsReleased == bootModeValid;
  endproperty
  a_release: assert property (p_release)
    else $error("pin release out of step");
  property p_gpio_off;
    !strapPinsReleased |-> strapPinsGpio == 2'h0;
  endproperty
  a_gpio_off: assert property (p_gpio_off)
    else $error("pins leak before release");
  property p_gpio_on;
    strapPinsReleased |->
      strapPinsGpio == $past({bootSourceStrapPin, downloadSelectStrapPin}, 2);
  endproperty
  a_gpio_on: assert property (p_gpio_on)
    else $error("released pins not passed through");
  property p_rtc_gpio;
    rtcPinsAsGpio == !rtcExtClockEn;
  endproperty
  a_rtc_gpio: assert property (p_rtc_gpio)
    else $error("crystal pins gpio wrong");
  // Last strap sample is the pin level four edges before valid is seen high
  property p_flash_src;
    $rose(bootModeValid) && $past(bootSourceStrapPin, 4)
      |-> bootMode == boot_strap_pkg::MODE_FLASH;
  endproperty
  a_flash_src: assert property (p_flash_src)
    else $error("source strap high did not give flash");
  property p_invalid_cap;
    $rose(bootModeValid) && !$past(bootSourceStrapPin, 4) && !$past(downloadSelectStrapPin, 4)
      |-> bootMode == boot_strap_pkg::MODE_INVALID;
  endproperty
  a_invalid_cap: assert property (p_invalid_cap)
    else $error("all-zero straps not flagged");
endmodule

bind boot_strap_mode_select boot_strap_checker #(.HOLD_CYC(HOLD_CYC)) i_chk (
  .clk(clk), .rst(rst),
  .downloadSelectStrapPin(downloadSelectStrapPin), .bootSourceStrapPin(bootSourceStrapPin),
  .strapPinsReleased(strapPinsReleased), .strapPinsGpio(strapPinsGpio),
  .bootMode(bootMode), .bootModeValid(bootModeValid), .invalidStraps(invalidStraps),
  .serialDownloadEn(serialDownloadEn), .spiDownloadEn(spiDownloadEn),
  .primarySerialPortLogEn(primarySerialPortLogEn), .rtcExtClockEn(rtcExtClockEn),
  .rtcPinsAsGpio(rtcPinsAsGpio)
);
`default_nettype wire

// [verif/strap_board.sv]
// Board strap resistors driving the two strap pins
`default_nettype none
module strap_board (
  // Clock for the wandering level
  input  wire logic clk,
  // Board choices
  input  wire logic selFloat,
  input  wire logic selLevel,
  input  wire logic srcFloat,
  input  wire logic srcLevel,
  // Strap pins
  output logic      selPin,
  output logic      srcPin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wander = 1'b0;

  always_ff @(posedge clk) begin
    wander <= ~wander;
  end
  assign selPin = selFloat ? wander : selLevel;
  assign srcPin = srcFloat ? 1'b1 : srcLevel;
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench for the boot strap mode select block
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1;
  logic selFloat = 1'b0, selLevel = 1'b1, srcFloat = 1'b0, srcLevel = 1'b1;
  wire logic selPin, srcPin;
  logic rel, spiEn, serEn, logEn, rtcExt, rtcSq, rtcGpio, x40, valid, inv;
  logic [1:0] gpio;
  logic [9:0] route;
  boot_strap_pkg::boot_mode_t bootMode;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors = 0;
  int total_checks = 0;

  always #50 clk = ~clk;

  strap_board i_board (.clk(clk), .selFloat(selFloat), .selLevel(selLevel),
    .srcFloat(srcFloat), .srcLevel(srcLevel), .selPin(selPin), .srcPin(srcPin));
  boot_strap_mode_select #(.HOLD_CYC(8)) i_dut (.clk(clk), .rst(rst),
    .downloadSelectStrapPin(selPin), .bootSourceStrapPin(srcPin),
    .strapPinsReleased(rel), .strapPinsGpio(gpio), .bootMode(bootMode),
    .bootModeValid(valid), .invalidStraps(inv), .serialDownloadEn(serEn),
    .spiDownloadEn(spiEn), .primarySerialPortLogEn(logEn), .rtcExtClockEn(rtcExt),
    .rtcSquareInput(rtcSq), .rtcPinsAsGpio(rtcGpio), .xtal40mSel(x40), .uartPinRoute(route),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    r = 2'h3;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No timeout here: the wait ends when bvalid is seen, or else the watchdog ends it
    while (!b) begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b = 1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, b;
    ar = 0;
    b = 0;
    r = 2'h3;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b) begin
      @(posedge clk);
      if (!ar && s_axi_arready === 1'b1) begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        b = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  task automatic boot(input logic sf, sl, rf, rl, spi);
    logic [1:0] r;
    int n;
    @(posedge clk);
    selFloat <= sf;
    selLevel <= sl;
    srcFloat <= rf;
    srcLevel <= rl;
    rst <= 1'b1;
    repeat (boot_strap_pkg::EN_LOW_CYC) @(posedge clk);
    rst <= 1'b0;
    if (spi) wr(boot_strap_pkg::ADDR_CONTROL, 32'h1, 4'hf, r);
    n = 0;
    while (valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
  endtask

  task automatic t_modes;
    logic [3:0] cs [5] = '{4'b0001, 4'b0101, 4'b0100, 4'b0000, 4'b1010};
    boot_strap_pkg::boot_mode_t m;
    logic [31:0] d;
    logic [1:0] r;
    logic bad;
    for (int i = 0; i < 5; i++) begin
      boot(cs[i][3], cs[i][2], cs[i][1], cs[i][0], 1'b0);
      m = (cs[i][1] | cs[i][0]) ? boot_strap_pkg::MODE_FLASH :
          cs[i][2] ? boot_strap_pkg::MODE_DOWNLOAD : boot_strap_pkg::MODE_INVALID;
      bad = (m == boot_strap_pkg::MODE_INVALID);
      `CHK(bootMode, m)
      `CHK(inv, bad)
      `CHK(serEn, m == boot_strap_pkg::MODE_DOWNLOAD)
      `CHK(logEn, m != boot_strap_pkg::MODE_INVALID)
      `CHK(rel, 1'b1)
      if (!cs[i][3]) begin
        rd(boot_strap_pkg::ADDR_STATUS, d, r);
        `CHK(d, {24'h0, cs[i][0], cs[i][2], bad, 1'b1, 2'b00, m})
      end
      @(posedge clk);
      selFloat <= 1'b0;
      srcFloat <= 1'b0;
      selLevel <= ~cs[i][2];
      srcLevel <= ~cs[i][0];
      repeat (3) @(posedge clk);
      `CHK(bootMode, m)
      `CHK(gpio, {~cs[i][0], ~cs[i][2]})
    end
    $display("test modes done");
  endtask

  task automatic t_spi;
    boot(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    `CHK(bootMode, boot_strap_pkg::MODE_SPI_DL)
    `CHK(spiEn, 1'b1)
    `CHK(serEn, 1'b0)
    $display("test spi download done");
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    boot(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    rd(boot_strap_pkg::ADDR_CONTROL, d, r);
    `CHK(d, boot_strap_pkg::CONTROL_RESET)
    `CHK(rtcGpio, 1'b1)
    rd(boot_strap_pkg::ADDR_UART_ROUTE, d, r);
    `CHK(d, boot_strap_pkg::UART_ROUTE_RESET)
    wr(boot_strap_pkg::ADDR_CONTROL, 32'hffff_ffff, 4'hf, r);
    `CHK(r, boot_strap_pkg::RESP_OKAY)
    wr(boot_strap_pkg::ADDR_CONTROL, 32'h0, 4'h0, r);
    rd(boot_strap_pkg::ADDR_CONTROL, d, r);
    `CHK(d, 32'hf)
    `CHK({rtcExt, rtcSq, rtcGpio}, 3'b110)
    `CHK(x40, 1'b1)
    wr(boot_strap_pkg::ADDR_CONTROL, 32'h0, 4'hf, r);
    `CHK({rtcExt, rtcGpio, x40}, 3'b010)
    wr(boot_strap_pkg::ADDR_UART_ROUTE, 32'h2a5, 4'hf, r);
    `CHK(route, 10'h2a5)
    rd(boot_strap_pkg::ADDR_ID, d, r);
    `CHK(d[31:24], boot_strap_pkg::REV_V11)
    wr(boot_strap_pkg::ADDR_STATUS, 32'h0, 4'hf, r);
    rd(boot_strap_pkg::ADDR_STATUS, d, r);
    `CHK(d[4], 1'b1)
    wr(8'h10, 32'h1, 4'hf, r);
    `CHK(r, boot_strap_pkg::RESP_SLVERR)
    rd(8'h10, d, r);
    `CHK({r, d}, {boot_strap_pkg::RESP_SLVERR, 32'h0})
    $display("test registers done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_modes;
    t_spi;
    t_regs;
    close_out;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule
`default_nettype wire
